// >>> rtl/sec_attr_cfg.svh
// register offsets, field masks, reset values and sram map constants
`ifndef SEC_ATTR_CFG_SVH
`define SEC_ATTR_CFG_SVH

`define REG_AW 12
`define OFS_IO_PORT 12'h020
`define OFS_SRAM_NS 12'h024
`define OFS_FLASH_NS 12'h028
`define OFS_VIO_EN 12'h02c
`define OFS_VIO_STS 12'h030

`define PORT_A_BIT 0
`define PORT_B_BIT 1
`define PORT_W 2
`define SRAM_SEC_W 12
`define VIO_W 19
`define VIO_MASK 19'h7fdf3
`define PBUS0_VIO_BIT 0
`define PBUS1_VIO_BIT 1
`define PORT_VIO_BIT 4
`define EXT_BUS_VIO_BIT 5
`define USB_HOST_VIO_BIT 6
`define CHECKSUM_VIO_BIT 7
`define SD_HOST_VIO_BIT 8
`define DMA0_VIO_BIT 10
`define DMA1_VIO_BIT 11
`define RAM_BANK0_VIO_BIT 12
`define RAM_BANK1_VIO_BIT 13
`define FLASH_CTRL_VIO_BIT 14
`define FLASH_DATA_VIO_BIT 15
`define SEC_UNIT_VIO_BIT 16
`define SYS_MGR_VIO_BIT 17
`define CRYPTO_VIO_BIT 18

`define PORT_RST 2'h0
`define SRAM_RST 12'h000
`define VIO_EN_RST 19'h00000
`define VIO_STS_RST 19'h00000
`define WORD_ZERO 32'h0000_0000

`define SRAM_S_BASE 32'h2000_0000
`define SRAM_NS_BASE 32'h3000_0000
`define SRAM_SEC_SIZE 32'h0000_2000
`define SRAM_SPAN 32'h0001_8000
`define SEC_IDX_HI 16
`define SEC_IDX_LO 13

`endif

// >>> rtl/sec_attr_pkg.sv
// types shared by the security attribution register block
package sec_attr_pkg;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
    } ahb_req_t;

    typedef struct packed {
        logic done;
        logic hit;
        logic ns_view;
        logic allowed;
        logic [3:0] section;
    } sram_check_t;

    typedef enum logic [1:0] {
        st_idle,
        st_rd_fetch
    } bus_state_t;

endpackage : sec_attr_pkg

// >>> rtl/security_attribution_violation_regs.sv
// attribution set registers, flash boundary readback and violation interrupt logic
`timescale 1ns/10ps
`include "sec_attr_cfg.svh"
// Overview of operation
// RL1 - port a/b bits set non-secure, sticky
// RL2 - twelve sram section bits, write-one sets
// RL3 - secure section n at 0x2000_0000 + n*0x2000
// RL4 - non-secure section n at 0x3000_0000 + n*0x2000
// RL5 - flash boundary read-only from user configuration
// RL6 - enable bits 0,1 gate peripheral bus violations
// RL7 - enable bits 4..7 gate port,bus,usb,checksum
// RL8 - enable 8 sd host, 10/11 dma, 9 reserved
// RL9 - enable 12,13 ram banks, 14 flash controller
// RL10 - enable 15 flash data, 16..18 unit,sys,crypto
// RL11 - status flag set by its source event
// RL12 - writing one clears a status flag
// RL13 - sram, enable, status reset to zero
// RL14 - interrupt while any enabled flag set
module security_attribution_violation_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire sec_attr_pkg::ahb_req_t ahb_req,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] flash_ns_boundary_value,
    input wire logic [`VIO_W-1:0] violation_event,
    input wire logic sram_query_valid,
    input wire logic [31:0] sram_query_addr,
    output sec_attr_pkg::sram_check_t sram_check,
    output logic port_a_nonsecure,
    output logic port_b_nonsecure,
    output logic [`SRAM_SEC_W-1:0] sram_section_nonsecure,
    output logic violation_irq
);
    import sec_attr_pkg::*;

    bus_state_t state_ff;
    bus_state_t nxt_state;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic hresp_ff;
    logic wr_pend_ff;
    logic [`REG_AW-1:0] wr_addr_ff;
    logic [`REG_AW-1:0] rd_addr_ff;
    logic [`PORT_W-1:0] port_ff;
    logic [`SRAM_SEC_W-1:0] sram_ff;
    logic [`VIO_W-1:0] vio_en_ff;
    logic [`VIO_W-1:0] vio_sts_ff;
    logic irq_ff;
    sram_check_t check_ff;
    logic [`PORT_W-1:0] nxt_port;
    logic [`SRAM_SEC_W-1:0] nxt_sram;
    logic [`VIO_W-1:0] nxt_vio_en;
    logic [`VIO_W-1:0] nxt_vio_sts;
    logic nxt_irq;
    sram_check_t nxt_check;

    // address phase capture
    wire addr_take = ahb_req.hsel & ahb_req.htrans[1] & hready;
    wire wr_take = addr_take & ahb_req.hwrite;
    wire rd_take = addr_take & ~ahb_req.hwrite;
    wire wr_commit = wr_pend_ff & hready;

    wire wr_io = wr_commit & (wr_addr_ff == `OFS_IO_PORT);
    wire wr_sram = wr_commit & (wr_addr_ff == `OFS_SRAM_NS);
    wire wr_en = wr_commit & (wr_addr_ff == `OFS_VIO_EN);
    wire wr_sts = wr_commit & (wr_addr_ff == `OFS_VIO_STS);

    // reads are served one cycle late so a write committing alongside is seen
    wire rd_io = (rd_addr_ff == `OFS_IO_PORT);
    wire rd_sram = (rd_addr_ff == `OFS_SRAM_NS);
    wire rd_flash = (rd_addr_ff == `OFS_FLASH_NS);
    wire rd_en = (rd_addr_ff == `OFS_VIO_EN);
    wire rd_sts = (rd_addr_ff == `OFS_VIO_STS);
    wire [31:0] rd_word = ({32{rd_io}} & {30'h0, port_ff})
        | ({32{rd_sram}} & {20'h0, sram_ff})
        // RL5 boundary from config
        | ({32{rd_flash}} & flash_ns_boundary_value)
        | ({32{rd_en}} & {13'h0, vio_en_ff})
        | ({32{rd_sts}} & {13'h0, vio_sts_ff});

    // RL1 write-one sets port
    assign nxt_port = port_ff | (wr_io ? hwdata[`PORT_W-1:0] : `PORT_RST);
    // RL2 write-one sets section
    assign nxt_sram = sram_ff | (wr_sram ? hwdata[`SRAM_SEC_W-1:0] : `SRAM_RST);
    // RL6 RL7 RL8 RL9 RL10 reserved enable bits stay zero
    assign nxt_vio_en = wr_en ? (hwdata[`VIO_W-1:0] & `VIO_MASK) : vio_en_ff;

    // RL11 RL12 event wins over a same-cycle clear
    wire [`VIO_W-1:0] sts_clr = wr_sts ? hwdata[`VIO_W-1:0] : `VIO_STS_RST;
    wire [`VIO_W-1:0] ev_masked = violation_event & `VIO_MASK;
    assign nxt_vio_sts = (vio_sts_ff & ~sts_clr) | ev_masked;

    // RL14 level request from enabled flags
    assign nxt_irq = |(nxt_vio_sts & nxt_vio_en);

    // RL11 enables and flags share positions
    wire pbus0_violation_irq_enable = vio_en_ff[`PBUS0_VIO_BIT];
    wire pbus1_violation_irq_enable = vio_en_ff[`PBUS1_VIO_BIT];
    wire port_violation_irq_enable = vio_en_ff[`PORT_VIO_BIT];
    wire ext_bus_violation_irq_enable = vio_en_ff[`EXT_BUS_VIO_BIT];
    wire usb_host_violation_irq_enable = vio_en_ff[`USB_HOST_VIO_BIT];
    wire checksum_violation_irq_enable = vio_en_ff[`CHECKSUM_VIO_BIT];
    wire sd_host_violation_irq_enable = vio_en_ff[`SD_HOST_VIO_BIT];
    wire dma0_violation_irq_enable = vio_en_ff[`DMA0_VIO_BIT];
    wire dma1_violation_irq_enable = vio_en_ff[`DMA1_VIO_BIT];
    wire ram_bank0_violation_irq_enable = vio_en_ff[`RAM_BANK0_VIO_BIT];
    wire ram_bank1_violation_irq_enable = vio_en_ff[`RAM_BANK1_VIO_BIT];
    wire flash_ctrl_violation_irq_enable = vio_en_ff[`FLASH_CTRL_VIO_BIT];
    wire flash_data_violation_irq_enable = vio_en_ff[`FLASH_DATA_VIO_BIT];
    wire sec_unit_violation_irq_enable = vio_en_ff[`SEC_UNIT_VIO_BIT];
    wire sys_mgr_violation_irq_enable = vio_en_ff[`SYS_MGR_VIO_BIT];
    wire crypto_violation_irq_enable = vio_en_ff[`CRYPTO_VIO_BIT];
    wire pbus0_violation_flag = vio_sts_ff[`PBUS0_VIO_BIT];
    wire pbus1_violation_flag = vio_sts_ff[`PBUS1_VIO_BIT];
    wire port_violation_flag = vio_sts_ff[`PORT_VIO_BIT];
    wire ext_bus_violation_flag = vio_sts_ff[`EXT_BUS_VIO_BIT];
    wire usb_host_violation_flag = vio_sts_ff[`USB_HOST_VIO_BIT];
    wire checksum_violation_flag = vio_sts_ff[`CHECKSUM_VIO_BIT];
    wire sd_host_violation_flag = vio_sts_ff[`SD_HOST_VIO_BIT];
    wire dma0_violation_flag = vio_sts_ff[`DMA0_VIO_BIT];
    wire dma1_violation_flag = vio_sts_ff[`DMA1_VIO_BIT];
    wire ram_bank0_violation_flag = vio_sts_ff[`RAM_BANK0_VIO_BIT];
    wire ram_bank1_violation_flag = vio_sts_ff[`RAM_BANK1_VIO_BIT];
    wire flash_ctrl_violation_flag = vio_sts_ff[`FLASH_CTRL_VIO_BIT];
    wire flash_data_violation_flag = vio_sts_ff[`FLASH_DATA_VIO_BIT];
    wire sec_unit_violation_flag = vio_sts_ff[`SEC_UNIT_VIO_BIT];
    wire sys_mgr_violation_flag = vio_sts_ff[`SYS_MGR_VIO_BIT];
    wire crypto_violation_flag = vio_sts_ff[`CRYPTO_VIO_BIT];

    // RL6 peripheral bus pending
    wire pbus_pend = (pbus0_violation_flag & pbus0_violation_irq_enable)
        | (pbus1_violation_flag & pbus1_violation_irq_enable);
    // RL7 port, bus, usb, checksum pending
    wire periph_pend = (port_violation_flag & port_violation_irq_enable)
        | (ext_bus_violation_flag & ext_bus_violation_irq_enable)
        | (usb_host_violation_flag & usb_host_violation_irq_enable)
        | (checksum_violation_flag & checksum_violation_irq_enable);
    // RL8 sd host, dma pending
    wire host_dma_pend = (sd_host_violation_flag & sd_host_violation_irq_enable)
        | (dma0_violation_flag & dma0_violation_irq_enable)
        | (dma1_violation_flag & dma1_violation_irq_enable);
    // RL9 ram banks, flash controller pending
    wire mem_pend = (ram_bank0_violation_flag & ram_bank0_violation_irq_enable)
        | (ram_bank1_violation_flag & ram_bank1_violation_irq_enable)
        | (flash_ctrl_violation_flag & flash_ctrl_violation_irq_enable);
    // RL10 flash data, unit, sys, crypto pending
    wire core_pend = (flash_data_violation_flag & flash_data_violation_irq_enable)
        | (sec_unit_violation_flag & sec_unit_violation_irq_enable)
        | (sys_mgr_violation_flag & sys_mgr_violation_irq_enable)
        | (crypto_violation_flag & crypto_violation_irq_enable);

    // RL3 RL4 sram view decode
    wire [31:0] q_off_s = sram_query_addr - `SRAM_S_BASE;
    wire [31:0] q_off_ns = sram_query_addr - `SRAM_NS_BASE;
    wire q_hit_s = q_off_s < `SRAM_SPAN;
    wire q_hit_ns = q_off_ns < `SRAM_SPAN;
    wire [3:0] q_sec = q_hit_ns ? q_off_ns[`SEC_IDX_HI:`SEC_IDX_LO] : q_off_s[`SEC_IDX_HI:`SEC_IDX_LO];
    // a section may be reached only through the view matching its attribute
    wire q_attr = sram_ff[q_sec];
    assign nxt_check.done = sram_query_valid;
    assign nxt_check.hit = sram_query_valid & (q_hit_s | q_hit_ns);
    assign nxt_check.ns_view = sram_query_valid & q_hit_ns;
    assign nxt_check.allowed = sram_query_valid & ((q_hit_s & ~q_attr) | (q_hit_ns & q_attr));
    assign nxt_check.section = sram_query_valid ? q_sec : 4'h0;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            st_idle: begin
                if (rd_take) begin
                    nxt_state = st_rd_fetch;
                end
            end
            st_rd_fetch: begin
                nxt_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= st_idle;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= `WORD_ZERO;
            hresp_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hreadyout_ff <= (state_ff == st_rd_fetch) | ~rd_take;
            if (state_ff == st_rd_fetch) begin
                hrdata_ff <= rd_word;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= {`REG_AW{1'b0}};
            rd_addr_ff <= {`REG_AW{1'b0}};
        end else begin
            if (hready) begin
                wr_pend_ff <= wr_take;
            end
            if (wr_take) begin
                wr_addr_ff <= ahb_req.haddr[`REG_AW-1:0];
            end
            if (rd_take) begin
                rd_addr_ff <= ahb_req.haddr[`REG_AW-1:0];
            end
        end
    end

    // RL13 all attribution and violation state resets to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_ff <= `PORT_RST;
            sram_ff <= `SRAM_RST;
            vio_en_ff <= `VIO_EN_RST;
            vio_sts_ff <= `VIO_STS_RST;
            irq_ff <= 1'b0;
            check_ff <= '0;
        end else begin
            port_ff <= nxt_port;
            sram_ff <= nxt_sram;
            vio_en_ff <= nxt_vio_en;
            vio_sts_ff <= nxt_vio_sts;
            irq_ff <= nxt_irq;
            check_ff <= nxt_check;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign port_a_nonsecure = port_ff[`PORT_A_BIT];
    assign port_b_nonsecure = port_ff[`PORT_B_BIT];
    assign sram_section_nonsecure = sram_ff;
    assign violation_irq = irq_ff;
    assign sram_check = check_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_port_sticky: assert property ((port_ff & $past(port_ff)) == $past(port_ff)) // RL1
        else $error("port attribution bit fell back to secure");

    a_port_set: assert property (wr_io |=> ((port_ff & $past(hwdata[`PORT_W-1:0])) == $past(hwdata[`PORT_W-1:0]))) // RL1
        else $error("port write of one did not set attribution");

    a_sram_set: assert property (wr_sram |=> (sram_ff == ($past(sram_ff) | $past(hwdata[`SRAM_SEC_W-1:0])))) // RL2
        else $error("sram section bits not or-ed with write data");

    a_sram_sticky: assert property (!wr_sram |=> $stable(sram_ff)) // RL2
        else $error("sram attribution changed without a write");

    a_secure_view: assert property ((sram_query_valid && q_off_s < `SRAM_SPAN) |=> // RL3
        (sram_check.hit && !sram_check.ns_view && sram_check.section == $past(q_off_s[`SEC_IDX_HI:`SEC_IDX_LO])))
        else $error("secure sram view decoded wrongly");

    a_nonsecure_view: assert property ((sram_query_valid && q_off_ns < `SRAM_SPAN) |=> // RL4
        (sram_check.hit && sram_check.ns_view
        && sram_check.allowed == $past(sram_ff[q_off_ns[`SEC_IDX_HI:`SEC_IDX_LO]])))
        else $error("non-secure sram view decoded wrongly");

    a_flash_read: assert property ((state_ff == st_rd_fetch && rd_flash) |=> (hrdata == $past(flash_ns_boundary_value))) // RL5
        else $error("flash boundary readback mismatch");

    a_enable_write: assert property (wr_en |=> (vio_en_ff == ($past(hwdata[`VIO_W-1:0]) & `VIO_MASK))) // RL6 RL7 RL8 RL9 RL10
        else $error("enable register did not take masked write data");

    a_enable_reserved: assert property ((vio_en_ff & ~`VIO_MASK) == `VIO_EN_RST) // RL8
        else $error("reserved enable bit set");

    a_flag_capture: assert property ((vio_sts_ff & $past(ev_masked)) == $past(ev_masked)) // RL11
        else $error("violation event lost");

    a_flag_clear: assert property ((wr_sts && (hwdata[`VIO_W-1:0] & ~ev_masked & vio_sts_ff) != 0) |=> // RL12
        ((vio_sts_ff & $past(hwdata[`VIO_W-1:0] & ~ev_masked)) == `VIO_STS_RST))
        else $error("write one did not clear flag");

    a_reset_zero: assert property ($rose(nrst) |-> (sram_ff == `SRAM_RST && vio_en_ff == `VIO_EN_RST && vio_sts_ff == `VIO_STS_RST)) // RL13
        else $error("registers not zero after reset");

    a_irq_level: assert property (violation_irq == |(vio_sts_ff & vio_en_ff)) // RL14
        else $error("interrupt does not match enabled flags");

    a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    a_port_hold: assert property (!wr_io |=> $stable(port_ff)) // RL1
        else $error("port attribution changed without a write");

    a_port_reset: assert property ($rose(nrst) |-> (port_ff == `PORT_RST)) // RL1
        else $error("ports not secure after reset");

    a_sram_keep: assert property ((sram_ff & $past(sram_ff)) == $past(sram_ff)) // RL2
        else $error("sram section fell back to secure");

    a_secure_allow: assert property ((sram_query_valid && q_off_s < `SRAM_SPAN) |=> // RL3
        (sram_check.allowed == !$past(sram_ff[q_off_s[`SEC_IDX_HI:`SEC_IDX_LO]])))
        else $error("secure view access check wrong");

    a_ns_section: assert property ((sram_query_valid && q_off_ns < `SRAM_SPAN) |=> // RL4
        (sram_check.section == $past(q_off_ns[`SEC_IDX_HI:`SEC_IDX_LO])))
        else $error("non-secure section index wrong");

    a_query_miss: assert property ((sram_query_valid && !q_hit_s && !q_hit_ns) |=> // RL3 RL4
        (sram_check.done && !sram_check.hit && !sram_check.allowed))
        else $error("address outside sram views reported as hit");

    a_enable_hold: assert property (!wr_en |=> $stable(vio_en_ff)) // RL6 RL7 RL8 RL9 RL10
        else $error("enable register changed without a write");

    a_pbus_gate: assert property (pbus_pend |-> violation_irq) // RL6
        else $error("enabled peripheral bus flag gave no interrupt");

    a_periph_gate: assert property (periph_pend |-> violation_irq) // RL7
        else $error("enabled peripheral flag gave no interrupt");

    a_host_dma_gate: assert property (host_dma_pend |-> violation_irq) // RL8
        else $error("enabled sd host or dma flag gave no interrupt");

    a_mem_gate: assert property (mem_pend |-> violation_irq) // RL9
        else $error("enabled memory flag gave no interrupt");

    a_core_gate: assert property (core_pend |-> violation_irq) // RL10
        else $error("enabled system flag gave no interrupt");

    a_flag_hold: assert property ((!wr_sts && ev_masked == `VIO_STS_RST) |=> $stable(vio_sts_ff)) // RL11
        else $error("status flag changed with no event or write");

    a_status_reserved: assert property ((vio_sts_ff & ~`VIO_MASK) == `VIO_STS_RST) // RL11
        else $error("reserved status bit set");

    a_flag_keep: assert property (wr_sts |=> // RL12
        ((vio_sts_ff & $past(vio_sts_ff & ~hwdata[`VIO_W-1:0])) == $past(vio_sts_ff & ~hwdata[`VIO_W-1:0])))
        else $error("write of zero cleared a flag");

    a_irq_quiet: assert property (!(pbus_pend | periph_pend | host_dma_pend | mem_pend | core_pend) |-> // RL14
        !violation_irq)
        else $error("interrupt with no enabled flag");

    a_irq_reset: assert property ($rose(nrst) |-> !violation_irq) // RL13
        else $error("interrupt raised straight after reset");

    a_write_ready: assert property (wr_take |=> hreadyout)
        else $error("write inserted a wait state");

    a_resp_okay: assert property (!hresp)
        else $error("error response on the bus");

    c_irq_rise: cover property ($rose(violation_irq));
    c_clear_vs_event: cover property (wr_sts && (hwdata[`VIO_W-1:0] & ev_masked) != 0);
    c_status_read: cover property (state_ff == st_rd_fetch && rd_sts && vio_sts_ff != 0);
    c_ns_allowed: cover property (sram_check.allowed && sram_check.ns_view);
    c_query_miss: cover property (sram_check.done && !sram_check.hit);

endmodule : security_attribution_violation_regs

// >>> tb/vio_source_model.sv
// stand-in for the bus security checkers that report violations
`timescale 1ns/10ps
module vio_source_model (
    input wire logic clk,
    input wire logic [18:0] fire,
    output logic [18:0] violation_event
);
    // any number of events per cycle, one per fire bit
    // each event follows fire one cycle later and stays high for as long as fire is held
    always_ff @(posedge clk) begin
        violation_event <= fire;
    end
endmodule : vio_source_model

// >>> tb/testbench.sv
// self-checking bench for the attribution and violation register block
`timescale 1ns/10ps
`include "sec_attr_cfg.svh"
module testbench;
    import sec_attr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    ahb_req_t ahb_req = '0;
    logic hready, hreadyout, hresp, port_a, port_b, irq;
    logic sq_valid = 1'b0;
    logic [31:0] hwdata = '0, hrdata, rd, sq_addr = '0;
    logic [31:0] flash_val = 32'h0004_0000;
    logic [18:0] fire = '0, vio_ev, bv;
    logic [11:0] sram_ns;
    sram_check_t sram_check;
    int err_total = 0, n_tests = 0;
    always #12.5 clk = ~clk;
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    security_attribution_violation_regs DUT (.clk(clk), .nrst(nrst), .ahb_req(ahb_req), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .flash_ns_boundary_value(flash_val), .violation_event(vio_ev), .sram_query_valid(sq_valid),
        .sram_query_addr(sq_addr), .sram_check(sram_check), .port_a_nonsecure(port_a),
        .port_b_nonsecure(port_b), .sram_section_nonsecure(sram_ns), .violation_irq(irq));
    vio_source_model src (.clk(clk), .fire(fire), .violation_event(vio_ev));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // no fixed latency assumed: each phase waits for ready, the watchdog bounds it
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        ahb_req <= '{1'b1, {20'h0, a}, 2'b10, w, 3'b010};
        do @(posedge clk); while (hready !== 1'b1);
        ahb_req <= '0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, '0);
    endtask : bus
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        chk(rd, exp);
    endtask : rdc
    task automatic query(input logic [31:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clk);
        sq_valid <= 1'b1;
        sq_addr <= a;
        @(posedge clk);
        sq_valid <= 1'b0;
        @(negedge clk);
        chk({24'h0, sram_check & m}, {24'h0, exp});
    endtask : query
    task automatic endt(input string s);
        $display("test %s done", s);
    endtask : endt
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rdc(`OFS_SRAM_NS, '0);
        rdc(`OFS_VIO_EN, '0);
        rdc(`OFS_VIO_STS, '0);
        rdc(`OFS_IO_PORT, '0);
        chk({17'h0, port_b, port_a, sram_ns, irq}, '0);
        endt("reset");
        bus(1'b1, `OFS_IO_PORT, 32'h0000_0001);
        @(negedge clk);
        chk({30'h0, port_b, port_a}, 32'h1);
        bus(1'b1, `OFS_IO_PORT, '0);
        rdc(`OFS_IO_PORT, 32'h1);
        bus(1'b1, `OFS_IO_PORT, 32'h0000_0002);
        rdc(`OFS_IO_PORT, 32'h3);
        chk({30'h0, port_b, port_a}, 32'h3);
        endt("ports");
        query(32'h2000_6000, 8'hd3, 8'hff);
        bus(1'b1, `OFS_SRAM_NS, 32'hffff_f0a5);
        rdc(`OFS_SRAM_NS, 32'h0000_00a5);
        bus(1'b1, `OFS_SRAM_NS, '0);
        rdc(`OFS_SRAM_NS, 32'h0000_00a5);
        chk({20'h0, sram_ns}, 32'h0000_00a5);
        query(32'h3000_0000, 8'hf0, 8'hff);
        query(32'h3000_3ffc, 8'he1, 8'hff);
        query(32'h2001_7ffc, 8'hdb, 8'hff);
        query(32'h2000_a000, 8'hc5, 8'hff);
        query(32'h2001_8000, 8'h80, 8'hd0);
        query(32'h2fff_fffc, 8'h80, 8'hd0);
        bus(1'b1, `OFS_SRAM_NS, 32'h0000_0fff);
        @(negedge clk);
        chk({20'h0, sram_ns}, 32'h0000_0fff);
        query(32'h3001_6000, 8'hfb, 8'hff);
        endt("sram");
        rdc(`OFS_FLASH_NS, 32'h0004_0000);
        bus(1'b1, `OFS_FLASH_NS, 32'hffff_ffff);
        flash_val <= 32'h0007_f800;
        rdc(`OFS_FLASH_NS, 32'h0007_f800);
        endt("flash");
        for (int i = 0; i < `VIO_W; i++) begin
            bv = 19'h1 << i;
            bus(1'b1, `OFS_VIO_EN, {13'h0, `VIO_MASK & ~bv});
            rdc(`OFS_VIO_EN, {13'h0, `VIO_MASK & ~bv});
            @(posedge clk);
            fire <= bv;
            @(posedge clk);
            fire <= '0;
            repeat (2) @(posedge clk);
            rdc(`OFS_VIO_STS, {13'h0, `VIO_MASK & bv});
            chk({31'h0, irq}, '0);
            bus(1'b1, `OFS_VIO_STS, '0);
            bus(1'b1, `OFS_VIO_EN, {13'h0, `VIO_MASK});
            @(negedge clk);
            chk({31'h0, irq}, {31'h0, |(`VIO_MASK & bv)});
            rdc(`OFS_VIO_STS, {13'h0, `VIO_MASK & bv});
            bus(1'b1, `OFS_VIO_STS, {13'h0, bv});
            rdc(`OFS_VIO_STS, '0);
            chk({31'h0, irq}, '0);
        end
        endt("violations");
        // a clear of every flag meets a pbus0 event in one cycle; the event must win
        fork
            bus(1'b1, `OFS_VIO_STS, {13'h0, `VIO_MASK});
            begin
                @(posedge clk);
                fire <= 19'h00001;
                @(posedge clk);
                fire <= '0;
            end
        join
        rdc(`OFS_VIO_STS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        endt("event over clear");
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdc(`OFS_IO_PORT, '0);
        rdc(`OFS_SRAM_NS, '0);
        rdc(`OFS_VIO_EN, '0);
        rdc(`OFS_VIO_STS, '0);
        chk({31'h0, irq}, '0);
        endt("second reset");
        report_and_stop();
    end
endmodule : testbench
